// ---- rtl/tdm_pkg.sv ----
// constants shared by the command and audio frame slave
//**********************************************************************
// Summary of operation
//**********************************************************************
package tdm_pkg;
	// field layout, bit numbers within a 32-bit field
	localparam int FIELD_LAST  = 31;
	localparam int B_ACQ       = 31;
	localparam int B_EXT       = 30;
	localparam int B_CHSEL     = 29;
	localparam int ID_HI       = 28;
	localparam int ID_LO       = 24;
	localparam int B_RW        = 23;
	localparam int REG_HI      = 22;
	localparam int REG_LO      = 16;
	localparam int DAT_HI      = 15;
	localparam int DAT_LO      = 8;
	localparam logic [4:0] POS_OE  = 5'h11;
	localparam logic [4:0] POS_WR  = 5'h07;
	localparam logic [4:0] ID_BCAST = 5'h1F;
	localparam logic [4:0] ID_NONE  = 5'h00;
	localparam logic [4:0] ID_MAX   = 5'h1E;
	// device registers reached by the link
	localparam logic [6:0] REG_CHAN  = 7'h13;
	localparam logic [6:0] REG_DEVID = 7'h17;
	localparam int CHAN_OFF_BIT = 0;
	localparam int SLOTS        = 2;
	// frame start pulse length that marks the mode
	localparam logic [2:0] FS_TDM_LEN = 3'h2;
	// bus registers, byte addresses
	localparam logic [7:0] WB_CTRL  = 8'h00;
	localparam logic [7:0] WB_STAT  = 8'h04;
	localparam logic [7:0] WB_LEFT  = 8'h08;
	localparam logic [7:0] WB_RIGHT = 8'h0C;
	localparam logic CTRL_RST = 1'h1;
endpackage

// ---- rtl/reg_if.sv ----
// carrier between the frame core and its bus registers
`timescale 1ns/1ps
interface reg_if;
	logic        link_en;
	logic        mode;
	logic        id_valid;
	logic [4:0]  dev_id;
	logic [23:0] left;
	logic [23:0] right;
	modport core (input link_en, output mode, id_valid, dev_id, left, right);
	modport bus  (output link_en, input mode, id_valid, dev_id, left, right);
endinterface

// ---- rtl/sync2.sv ----
// two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module sync2 #(
	parameter int W = 1
) (
	input  wire logic         core_clk, // sampling clock
	input  wire logic         rstn,     // async reset, low
	input  wire logic [W-1:0] d,        // asynchronous levels
	output logic      [W-1:0] q         // synchronised levels
);
	logic [W-1:0] meta_reg;

	// first stage is read by the second only
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			meta_reg <= '0;
			q        <= '0;
		end
		else
		begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule

// ---- rtl/wb_regs.sv ----
// classic wishbone slave for control, status and audio
`timescale 1ns/1ps
module wb_regs (
	input  wire logic        core_clk, // system clock
	input  wire logic        rstn,     // async reset, low
	input  wire logic        wb_cyc_i, // cycle
	input  wire logic        wb_stb_i, // strobe
	input  wire logic        wb_we_i,  // write
	input  wire logic [7:0]  wb_adr_i, // byte address
	input  wire logic [3:0]  wb_sel_i, // byte lanes
	input  wire logic [31:0] wb_dat_i, // write data
	output logic      [31:0] wb_dat_o, // read data
	output logic             wb_ack_o, // acknowledge
	reg_if.bus               rif       // core side
);
	logic link_en_reg;
	logic req;

	assign req         = wb_cyc_i & wb_stb_i;
	assign rif.link_en = link_en_reg;

	// one wait state; ack drops the cycle after
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= req & ~wb_ack_o;
	end

	// write lands on the edge the master sees ack
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			link_en_reg <= tdm_pkg::CTRL_RST;
		else if (req & wb_ack_o & wb_we_i & wb_sel_i[0] & (wb_adr_i == tdm_pkg::WB_CTRL))
			link_en_reg <= wb_dat_i[0];
	end

	// read data captured with ack; unmapped reads zero
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			wb_dat_o <= 32'h0;
		else if (req & ~wb_ack_o)
		begin
			case (wb_adr_i)
				tdm_pkg::WB_CTRL:  wb_dat_o <= {31'h0, link_en_reg};
				tdm_pkg::WB_STAT:  wb_dat_o <= {19'h0, rif.dev_id, 6'h0, rif.id_valid, rif.mode};
				tdm_pkg::WB_LEFT:  wb_dat_o <= {8'h0, rif.left};
				tdm_pkg::WB_RIGHT: wb_dat_o <= {8'h0, rif.right};
				default:           wb_dat_o <= 32'h0;
			endcase
		end
	end
endmodule

// ---- rtl/tdm_command_audio_slave.sv ----
// frame decoder, register file and daisy chain of the serial slave
`timescale 1ns/1ps
module tdm_command_audio_slave (
	input  wire logic        core_clk,        // 250 MHz system clock
	input  wire logic        rstn,            // async reset, low
	input  wire logic        bit_clock,       // serial bit clock pin
	input  wire logic        frame_start,     // frame start pin
	input  wire logic        serial_in,       // command and audio in
	input  wire logic        chain_in,        // daisy chain in
	output logic             serial_out,      // read data out
	output logic             serial_out_oe_n, // low while driving
	output logic             chain_out,       // daisy chain out
	input  wire logic        wb_cyc_i,        // bus cycle
	input  wire logic        wb_stb_i,        // bus strobe
	input  wire logic        wb_we_i,         // bus write
	input  wire logic [7:0]  wb_adr_i,        // bus address
	input  wire logic [3:0]  wb_sel_i,        // bus byte lanes
	input  wire logic [31:0] wb_dat_i,        // bus write data
	output logic      [31:0] wb_dat_o,        // bus read data
	output logic             wb_ack_o         // bus acknowledge
);
	//******************************************************************
	// types and helpers
	//******************************************************************
	typedef enum logic [2:0] {F_IDLE, F_CMD, F_EXT, F_AUDIO, F_ACQ} field_e;

	// field names this device, never id 0, never out chain
	function automatic logic addressed(input logic [31:0] w, input logic [4:0] id, input logic ok);
		addressed = ok & ~w[tdm_pkg::B_CHSEL] & (w[tdm_pkg::ID_HI:tdm_pkg::ID_LO] == id)
			& (id != tdm_pkg::ID_NONE);
	endfunction

	//******************************************************************
	// pin sampling and bit clock edges
	//******************************************************************
	reg_if rif ();

	logic [3:0] sync_q;
	logic       s_bclk, s_fs, s_din, s_cin;
	logic       bclk_d_reg, rise, fall;

	sync2 #(.W(4)) u_sync (
		.core_clk (core_clk),
		.rstn     (rstn),
		.d        ({bit_clock, frame_start, serial_in, chain_in}),
		.q        (sync_q)
	);

	wb_regs u_regs (
		.core_clk (core_clk),
		.rstn     (rstn),
		.wb_cyc_i (wb_cyc_i),
		.wb_stb_i (wb_stb_i),
		.wb_we_i  (wb_we_i),
		.wb_adr_i (wb_adr_i),
		.wb_sel_i (wb_sel_i),
		.wb_dat_i (wb_dat_i),
		.wb_dat_o (wb_dat_o),
		.wb_ack_o (wb_ack_o),
		.rif      (rif.bus)
	);

	assign {s_bclk, s_fs, s_din, s_cin} = sync_q;

	// edge finder on the synchronised bit clock
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			bclk_d_reg <= 1'b0;
		else
			bclk_d_reg <= s_bclk;
	end

	assign rise = s_bclk & ~bclk_d_reg;
	assign fall = ~s_bclk & bclk_d_reg;

	//******************************************************************
	// frame start length and mode entry
	//******************************************************************
	logic       fs_d_reg, good_reg, mode_reg, sof;
	logic [2:0] fs_len_reg;

	assign sof = rise & s_fs & ~fs_d_reg;

	// count high bits of the frame start pulse, saturating
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			fs_d_reg   <= 1'b0;
			fs_len_reg <= 3'h0;
		end
		else if (rise)
		begin
			fs_d_reg <= s_fs;
			if (sof)
				fs_len_reg <= 3'h1;
			else if (s_fs & (fs_len_reg != 3'h7))
				fs_len_reg <= fs_len_reg + 3'h1;
		end
	end

	// a wide pulse drops the mode at once
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			good_reg <= 1'b0;
			mode_reg <= 1'b0;
		end
		else if (!rif.link_en)
		begin
			good_reg <= 1'b0;
			mode_reg <= 1'b0;
		end
		else if (rise & fs_d_reg & ~s_fs)
		begin
			good_reg <= (fs_len_reg == tdm_pkg::FS_TDM_LEN);
			mode_reg <= (fs_len_reg == tdm_pkg::FS_TDM_LEN) & good_reg;
		end
	end

	//******************************************************************
	// field tracking
	//******************************************************************
	field_e      kind_reg, next_kind;
	logic [4:0]  pos_reg, cur, fidx_reg, my_id;
	logic [31:0] cmd_reg;
	logic [1:0]  own_reg;
	logic [7:0]  regs [128];
	logic        id_valid_reg, is_cmd, acq_now, chan_on, rd, wr;

	// bit number of the bit arriving on this rising edge
	assign cur     = sof ? 5'(tdm_pkg::FIELD_LAST) : pos_reg - 5'h1;
	assign is_cmd  = (kind_reg == F_CMD) | (kind_reg == F_EXT);
	assign acq_now = (kind_reg == F_CMD) & cmd_reg[tdm_pkg::B_ACQ];
	assign my_id   = regs[tdm_pkg::REG_DEVID][4:0];
	assign chan_on = ~regs[tdm_pkg::REG_CHAN][tdm_pkg::CHAN_OFF_BIT];
	assign rd      = is_cmd & ~acq_now & cmd_reg[tdm_pkg::B_RW]
		& addressed(cmd_reg, my_id, id_valid_reg);
	assign wr      = rise & (cur == tdm_pkg::POS_WR) & is_cmd & ~acq_now & ~cmd_reg[tdm_pkg::B_RW]
		& (addressed(cmd_reg, my_id, id_valid_reg)
		| (cmd_reg[tdm_pkg::ID_HI:tdm_pkg::ID_LO] == tdm_pkg::ID_BCAST));

	// what follows a finished field
	always_comb
	begin
		next_kind = kind_reg;
		case (kind_reg)
			F_CMD:   next_kind = cmd_reg[tdm_pkg::B_ACQ] ? F_ACQ :
				(cmd_reg[tdm_pkg::B_EXT] ? F_EXT : F_AUDIO);
			F_EXT:   next_kind = cmd_reg[tdm_pkg::B_EXT] ? F_EXT : F_AUDIO;
			default: next_kind = kind_reg;
		endcase
	end

	// shift bits in on rising edges, msb first
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			kind_reg <= F_IDLE;
			pos_reg  <= 5'h0;
			fidx_reg <= 5'h0;
			cmd_reg  <= 32'h0;
		end
		else if (!mode_reg)
			kind_reg <= F_IDLE;
		else if (rise)
		begin
			cmd_reg[cur] <= s_din;
			pos_reg      <= cur;
			if (sof)
			begin
				kind_reg <= F_CMD;
				fidx_reg <= 5'h0;
			end
			else if ((kind_reg != F_IDLE) & (cur == 5'h0))
			begin
				kind_reg <= next_kind;
				if (fidx_reg != 5'h1F)
					fidx_reg <= fidx_reg + 5'h1;
			end
		end
	end

	// slot ownership; chain in high on the last bit hands us the next slot
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			own_reg <= 2'h0;
		else if (sof)
			own_reg <= 2'h0;
		else if (rise & (cur == 5'h0) & (next_kind == F_AUDIO) & chan_on)
		begin
			case (own_reg)
				2'h0:    own_reg <= s_cin ? 2'h1 : 2'h0;
				2'h1:    own_reg <= 2'(tdm_pkg::SLOTS);
				default: own_reg <= 2'h3;
			endcase
		end
	end

	//******************************************************************
	// register file, identifier and audio capture
	//******************************************************************
	logic [23:0] left_reg, right_reg;

	// acquisition and host writes share one writer of the array
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < 128; i++)
				regs[i] <= 8'h0;
			id_valid_reg <= 1'b0;
		end
		else if (rise & acq_now & (cur == 5'h0))
			id_valid_reg <= 1'b0;
		else if (rise & (kind_reg == F_ACQ) & (cur == 5'(tdm_pkg::FIELD_LAST)) & ~id_valid_reg
			& s_cin & (fidx_reg != 5'h0) & (fidx_reg <= tdm_pkg::ID_MAX))
		begin
			regs[tdm_pkg::REG_DEVID] <= {3'h0, fidx_reg};
			id_valid_reg             <= 1'b1;
		end
		else if (wr)
			regs[cmd_reg[tdm_pkg::REG_HI:tdm_pkg::REG_LO]] <= cmd_reg[tdm_pkg::DAT_HI:tdm_pkg::DAT_LO];
	end

	// the 24-bit sample sits in bits 31:8 of an owned slot
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			left_reg  <= 24'h0;
			right_reg <= 24'h0;
		end
		else if (rise & (cur == tdm_pkg::POS_WR) & (kind_reg == F_AUDIO))
		begin
			if (own_reg == 2'h1)
				left_reg <= cmd_reg[31:8];
			else if (own_reg == 2'(tdm_pkg::SLOTS))
				right_reg <= cmd_reg[31:8];
		end
	end

	assign rif.mode     = mode_reg;
	assign rif.id_valid = id_valid_reg;
	assign rif.dev_id   = my_id;
	assign rif.left     = left_reg;
	assign rif.right    = right_reg;

	//******************************************************************
	// serial output and chain output, changed on falling edges
	//******************************************************************
	// driver opens one bit ahead of bit 15, closes before bit 7
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			serial_out      <= 1'b0;
			serial_out_oe_n <= 1'b1;
		end
		else if (!mode_reg)
			serial_out_oe_n <= 1'b1;
		else if (fall)
		begin
			serial_out_oe_n <= ~(rd & (pos_reg <= tdm_pkg::POS_OE) & (pos_reg >= 5'h9));
			serial_out      <= (rd & (pos_reg <= 5'h10) & (pos_reg >= 5'h9))
				& regs[cmd_reg[tdm_pkg::REG_HI:tdm_pkg::REG_LO]][3'(pos_reg - 5'h9)];
		end
	end

	// the passed level is taken from the synchronised input
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			chain_out <= 1'b0;
		else if (fall)
		begin
			if (kind_reg == F_ACQ)
				chain_out <= id_valid_reg & (fidx_reg == my_id + 5'h1);
			else if (chan_on)
				chain_out <= (kind_reg == F_AUDIO) & (own_reg == 2'(tdm_pkg::SLOTS));
			else
				chain_out <= s_cin;
		end
	end

	//******************************************************************
	// checks
	//******************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	property p_oe_window;
		!serial_out_oe_n |-> rd && pos_reg >= 5'h8 && pos_reg <= 5'h11;
	endproperty
	a_oe_window: assert property (p_oe_window) else $error("driver on outside read");

	property p_oe_early;
		$fell(serial_out_oe_n) |-> pos_reg == 5'h11;
	endproperty
	a_oe_early: assert property (p_oe_early) else $error("driver opened late");

	property p_low_byte;
		fall && pos_reg == 5'h8 |=> serial_out_oe_n;
	endproperty
	a_low_byte: assert property (p_low_byte) else $error("low byte driven");

	property p_out_on_fall;
		$changed(serial_out) |-> $past(fall);
	endproperty
	a_out_on_fall: assert property (p_out_on_fall) else $error("output moved off falling edge");

	property p_bcast;
		wr && cmd_reg[28:24] == 5'h1F |=> regs[cmd_reg[22:16]] == cmd_reg[15:8];
	endproperty
	a_bcast: assert property (p_bcast) else $error("broadcast write lost");

	property p_zero_id;
		rise && cur == 5'h7 && is_cmd && cmd_reg[28:24] == 5'h0 |-> !wr;
	endproperty
	a_zero_id: assert property (p_zero_id) else $error("id zero selected");

	property p_ext_follows;
		rise && cur == 5'h0 && kind_reg == F_CMD && !cmd_reg[31] && cmd_reg[30] |=> kind_reg == F_EXT;
	endproperty
	a_ext_follows: assert property (p_ext_follows) else $error("extended field missed");

	property p_mode_entry;
		$rose(mode_reg) |-> $past(fs_len_reg) == 3'h2 && $past(good_reg);
	endproperty
	a_mode_entry: assert property (p_mode_entry) else $error("mode entered wrongly");

	property p_pass;
		fall && !chan_on && kind_reg != F_ACQ |=> chain_out == $past(s_cin);
	endproperty
	a_pass: assert property (p_pass) else $error("chain not passed");

	property p_top_id;
		rise && kind_reg == F_ACQ && cur == 5'h1F && fidx_reg == 5'h1 && s_cin && !id_valid_reg
			|=> id_valid_reg && my_id == 5'h1;
	endproperty
	a_top_id: assert property (p_top_id) else $error("top of chain not id 1");
endmodule

// ---- testbench/tdm_host_model.sv ----
// host side model that drives link frames and records the answers
`timescale 1ns/1ps
module tdm_host_model (
	input  wire logic core_clk,        // pacing clock
	output logic      bit_clock,       // link bit clock
	output logic      frame_start,     // frame start level
	output logic      serial_in,       // command and audio bits
	output logic      chain_in,        // stands in for the chain ahead
	input  wire logic serial_out,      // read data from device
	input  wire logic serial_out_oe_n, // low while device drives
	input  wire logic chain_out        // chain to next device
);
	logic [31:0] fld [0:7];
	logic [31:0] rd_oe;
	logic [31:0] rd_dat;
	int          cnt [0:7];
	// idle levels; the bit clock stands low outside frames
	initial
	begin
		bit_clock = 1'b0;
		frame_start = 1'b0;
		serial_in = 1'b0;
		chain_in = 1'b0;
	end
	// half a bit period, 80 ns
	task automatic half();
		repeat (20) @(posedge core_clk);
	endtask
	// one frame of n fields; chain_in high through field chain_at
	task automatic frame(input int n, input int chain_at);
		@(posedge core_clk);
		rd_oe = '0;
		rd_dat = '0;
		for (int f = 0; f < 8; f++)
			cnt[f] = 0;
		for (int f = 0; f < n; f++)
		begin
			for (int b = 31; b >= 0; b--)
			begin
				bit_clock   <= 1'b0;
				serial_in   <= fld[f][b]; // msb first
				frame_start <= (f == 0 && b >= 30); // two-bit pulse
				chain_in    <= (f == chain_at); // high for every bit of field chain_at
				half();
				bit_clock <= 1'b1; // data held across the rise
				if (f == 0)
				begin
					rd_oe[b] = (serial_out_oe_n === 1'b0);
					rd_dat[b] = (serial_out_oe_n === 1'b0) ? serial_out : ~serial_out; // released line reads inverted
				end
				cnt[f] += int'(chain_out === 1'b1);
				half();
			end
		end
		// released data line shows the inverse so a stale value never passes
		bit_clock <= 1'b0;
		serial_in <= ~serial_in;
		chain_in <= 1'b0;
		half();
	endtask
endmodule

// ---- testbench/tdm_command_audio_slave_tb_top.sv ----
// testbench for the command and audio frame slave
`timescale 1ns/1ps
module tdm_command_audio_slave_tb_top;
	logic        core_clk;
	logic        rstn;
	logic        bit_clock;
	logic        frame_start;
	logic        serial_in;
	logic        chain_in;
	logic        serial_out;
	logic        serial_out_oe_n;
	logic        chain_out;
	logic        wb_cyc_i;
	logic        wb_stb_i;
	logic        wb_we_i;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic [31:0] rdat;
	int          fails;
	int          check_count;

	always #2 core_clk = ~core_clk;

	tdm_command_audio_slave dut (.core_clk(core_clk), .rstn(rstn), .bit_clock(bit_clock),
		.frame_start(frame_start), .serial_in(serial_in), .chain_in(chain_in), .serial_out(serial_out),
		.serial_out_oe_n(serial_out_oe_n), .chain_out(chain_out), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

	tdm_host_model host (.core_clk(core_clk), .bit_clock(bit_clock), .frame_start(frame_start),
		.serial_in(serial_in), .chain_in(chain_in), .serial_out(serial_out),
		.serial_out_oe_n(serial_out_oe_n), .chain_out(chain_out));

	//**********************************************************************
	// checking and closing
	//**********************************************************************
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	//**********************************************************************
	// bus and link access
	//**********************************************************************
	// one classic cycle; the request stands until ack is sampled high
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= 4'hF;
		wb_dat_i <= d;
		@(posedge core_clk);
		while (wb_ack_o !== 1'b1 && n < 20)
		begin
			@(posedge core_clk);
			n++;
		end
		if (n == 20)
		begin
			fails++;
			conclude();
		end
		rdat = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic wb_read(input logic [7:0] a, input logic [31:0] exp, input string name);
		wb(1'b0, a, 32'h0);
		check(name, rdat, exp);
	endtask

	function automatic logic [31:0] cmd(input logic [2:0] top, input logic [4:0] id, input logic rd,
		input logic [6:0] r, input logic [7:0] d);
		return {top, id, rd, r, d, 8'h00};
	endfunction

	// link read: driver on from the bit 16 slot, low byte never driven
	task automatic link_read(input logic [4:0] id, input logic [6:0] r, input logic [7:0] exp);
		host.fld[0] = cmd(3'b000, id, 1'b1, r, 8'h00);
		host.frame(1, 9);
		check("read enable", host.rd_oe, 32'h0001FF00);
		check("read data", {24'h0, host.rd_dat[15:8]}, {24'h0, exp});
	endtask

	//**********************************************************************
	// main sequence
	//**********************************************************************
	initial
	begin
		core_clk = 1'b0;
		rstn = 1'b0;
		{wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		fails = 0;
		check_count = 0;
		repeat (3) @(posedge core_clk);
		rstn <= 1'b1;
		wb_read(tdm_pkg::WB_CTRL, 32'h1, "ctrl reset");
		wb_read(tdm_pkg::WB_STAT, 32'h0, "status reset");
		wb_read(8'h10, 32'h0, "unmapped");
		$display("test reset done");
		// two short frame starts; ignored commands meanwhile
		host.fld[0] = 32'h0;
		repeat (2) host.frame(1, 9);
		wb_read(tdm_pkg::WB_STAT, 32'h1, "mode entry");
		host.fld[0] = cmd(3'b100, 5'h00, 1'b0, 7'h00, 8'h00);
		host.fld[1] = 32'h0;
		host.fld[2] = 32'h0;
		host.frame(3, 1);
		wb_read(tdm_pkg::WB_STAT, 32'h103, "acquired id");
		check("acq chain out", host.cnt[2], 32'd32);
		link_read(5'h01, tdm_pkg::REG_DEVID, 8'h01);
		$display("test acquisition done");
		// output chain selected: a read must stay silent
		host.fld[0] = cmd(3'b001, 5'h01, 1'b1, tdm_pkg::REG_DEVID, 8'h00);
		host.frame(1, 9);
		check("out chain read", host.rd_oe, 32'h0);
		// audio frame, command to nobody would turn channels off
		host.fld[0] = cmd(3'b000, tdm_pkg::ID_NONE, 1'b0, tdm_pkg::REG_CHAN, 8'h01);
		host.fld[1] = 32'h12345600;
		host.fld[2] = 32'hABCDEF00;
		host.frame(3, 0);
		check("chain slot one", host.cnt[1], 32'd0);
		check("chain slot two", host.cnt[2], 32'd32);
		wb_read(tdm_pkg::WB_LEFT, 32'h123456, "left");
		wb_read(tdm_pkg::WB_RIGHT, 32'hABCDEF, "right");
		link_read(5'h01, tdm_pkg::REG_CHAN, 8'h00);
		$display("test audio done");
		// broadcast write with an extended field whose top bit is reserved
		host.fld[0] = cmd(3'b010, tdm_pkg::ID_BCAST, 1'b0, tdm_pkg::REG_CHAN, 8'h01);
		host.fld[1] = cmd(3'b100, 5'h01, 1'b0, tdm_pkg::REG_DEVID, 8'h01);
		host.frame(2, 9);
		check("write silent", host.rd_oe, 32'h0);
		wb_read(tdm_pkg::WB_STAT, 32'h103, "extended top bit");
		link_read(5'h01, tdm_pkg::REG_CHAN, 8'h01);
		$display("test extended done");
		// channels off: the chain passes straight through; the first bit of a frame has no fall before it
		host.fld[0] = 32'h0;
		host.frame(3, 1);
		check("chain pass", host.cnt[0] + host.cnt[1], 32'd32);
		check("chain pass idle", host.cnt[0] + host.cnt[2], 32'd0);
		wb(1'b1, tdm_pkg::WB_CTRL, 32'h0);
		wb(1'b0, tdm_pkg::WB_STAT, 32'h0);
		check("mode forced off", {31'h0, rdat[0]}, 32'h0);
		$display("test pass through done");
		conclude();
	end
endmodule
